// *** design/ctrl_port_pkg.sv ***
// constants and types for the two-wire control port and register file
package ctrl_port_pkg;

    // =====================================================================
    // slave address
    // =====================================================================
    localparam logic [5:0] SLAVE_ADDR_HI   = 6'h09;   // fixed upper six bits 001001
    localparam int         BYTE_LAST_BIT   = 7;
    localparam logic [3:0] BIT_CNT_ACK     = 4'h8;

    // =====================================================================
    // register map
    // =====================================================================
    localparam int         ADDR_W          = 7;
    localparam int         REG_COUNT       = 80;
    localparam logic [6:0] ADDR_LAST       = 7'h4F;
    localparam logic [6:0] ADDR_FIRST      = 7'h00;
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;

    localparam logic [6:0] POWER_MANAGEMENT_A   = 7'h00;
    localparam logic [6:0] POWER_MANAGEMENT_B   = 7'h01;
    localparam logic [6:0] SPEAKER_ROUTE        = 7'h02;
    localparam logic [6:0] SERIAL_MODE          = 7'h03;
    localparam logic [6:0] LIMITER_TIMER_SELECT = 7'h06;
    localparam logic [6:0] VOLUME_MODE          = 7'h09;

    // power_management_a fields
    localparam int REFERENCE_POWER_BIT    = 0;
    localparam int MONO_INPUT_POWER_BIT   = 1;
    localparam int CONVERTER_POWER_BIT    = 2;
    localparam int SPEAKER_AMP_POWER_BIT  = 4;
    // power_management_b fields
    localparam int LOOP_POWER_BIT         = 0;
    localparam int CLOCK_OUTPUT_ENABLE    = 1;
    localparam int LEFT_PHONES_POWER_BIT  = 4;
    localparam int RIGHT_PHONES_POWER_BIT = 5;
    // speaker_route fields
    localparam int SPEAKER_POWER_SAVE_BIT = 7;
    // serial_mode fields
    localparam int RATE_SELECT_LSB        = 6;
    localparam int BIT_CLOCK_POLARITY     = 5;
    localparam int FRAME_CLOCK_POLARITY   = 4;
    // volume_mode fields
    localparam int VOLUME_TRANSITION_TIME = 7;

    // =====================================================================
    // timing
    // =====================================================================
    localparam logic [10:0] VOLUME_RAMP_SLOW = 11'd1061;   // in 1/fs units
    localparam logic [10:0] VOLUME_RAMP_FAST = 11'd256;    // in 1/fs units
    localparam int          CLK_DIV_W        = 4;

    // =====================================================================
    // link phases
    // =====================================================================
    typedef enum logic [2:0] {
        PH_ADDR,
        PH_REG,
        PH_WDATA,
        PH_READ,
        PH_IGNORE
    } link_phase_t;

endpackage

// *** design/ctrl_port.sv ***
// two-wire control port slave with register file and power control outputs
//
// Summary of operation
// R1: detect start and stop on the bus
// R2: match address 001001 plus select pin
// R3: acknowledge own address, then run operation
// R4: direction bit one reads, zero writes
// R5: first written byte loads address counter
// R6: receive data bytes msb first, acknowledge each
// R7: write stores then increments, wraps past 4F
// R8: read increments after each byte, wraps
// R9: change data line only while clock low
// R10: counter keeps last address plus one
// R11: master ack continues read, nack stops
// R12: master sets address by dummy write first
// R13: power-down pin resets every register
// R14: software writes zero to unused bits
// R15: power bits default off, one powers up
// R16: software sets mono bit with amplifiers
// R17: software keeps reference on while powered
// R18: all bits zero powers down, keeps registers
// R19: clock output low unless enabled, rate select
// R20: power-save bit clear floats positive, mids negative; bit set drives positive
// R21: bit clock polarity swaps launch/capture edges
// R22: transition time 1061 or 256 frames
// R23: bus runs up to 400 kHz
// R24: unmatched address releases line until start
`timescale 1ns/100ps
`default_nettype none

module ctrl_port
    import ctrl_port_pkg::*;
(
    input  wire logic         ref_clk_i,
    input  wire logic         nrst_i,
    input  wire logic         scl_i,
    input  wire logic         sda_i,
    output logic              sda_o,
    output logic              sda_oe_o,
    input  wire logic         addr_select_pin_i,
    input  wire logic         power_down_pin_n_i,
    output logic              converter_power_o,
    output logic              speaker_amp_power_o,
    output logic              mono_input_power_o,
    output logic              reference_power_o,
    output logic              left_phones_power_o,
    output logic              right_phones_power_o,
    output logic              loop_power_o,
    output logic              all_blocks_down_o,
    output logic              clock_out_o,
    output logic              speaker_pos_out_drive_o,
    output logic              speaker_neg_out_mid_o,
    output logic              serial_audio_out_on_fall_o,
    output logic              serial_audio_in_on_rise_o,
    output logic              frame_clock_polarity_o,
    output logic [10:0]       volume_ramp_frames_o,
    output logic              bus_busy_o
);
    import ctrl_port_pkg::*;

    // =====================================================================
    // helpers
    // =====================================================================
    function automatic logic [ADDR_W-1:0] addr_step(input logic [ADDR_W-1:0] a);
        if (a >= ADDR_LAST)
            addr_step = ADDR_FIRST;
        else
            addr_step = a + 7'h01;
    endfunction

    function automatic logic in_map(input logic [ADDR_W-1:0] a);
        in_map = (a <= ADDR_LAST);
    endfunction

    // =====================================================================
    // pin synchronisers, reference domain
    // =====================================================================
    logic scl_s1_reg, scl_s2_reg;
    logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
    logic pdn_s1_reg, pdn_s2_reg;

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_s3_reg <= 1'b1;
        end
        else
        begin
            scl_s1_reg <= scl_i;
            scl_s2_reg <= scl_s1_reg;                               // [R23]
            sda_s1_reg <= sda_i;
            sda_s2_reg <= sda_s1_reg;
            sda_s3_reg <= sda_s2_reg;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            pdn_s1_reg <= 1'b0;
            pdn_s2_reg <= 1'b0;
        end
        else
        begin
            pdn_s1_reg <= power_down_pin_n_i;
            pdn_s2_reg <= pdn_s1_reg;
        end
    end

    logic regs_rst;
    assign regs_rst = !nrst_i || !pdn_s2_reg;                       // [R13]

    // =====================================================================
    // start / stop detection and link idle
    // =====================================================================
    logic start_seen, stop_seen;
    logic link_idle_reg;

    assign start_seen = scl_s2_reg && sda_s3_reg && !sda_s2_reg;    // [R1]
    assign stop_seen  = scl_s2_reg && !sda_s3_reg && sda_s2_reg;    // [R1]

    // idle holds the link logic in reset between stop and start
    always_ff @(posedge ref_clk_i)
    begin
        if (regs_rst)
            link_idle_reg <= 1'b1;
        else if (stop_seen)
            link_idle_reg <= 1'b1;                                  // [R24]
        else if (start_seen)
            link_idle_reg <= 1'b0;
    end

    assign bus_busy_o = !link_idle_reg;

    // =====================================================================
    // link domain, bus clock rising edge
    // =====================================================================
    link_phase_t   phase_reg;
    logic [3:0]    bit_cnt_reg;
    logic [6:0]    rx_shift_reg;
    logic          rd_first_reg;
    logic          wr_tgl_reg;
    logic          rd_tgl_reg;
    logic [7:0]    ev_byte_reg;
    logic          ev_is_addr_reg;
    logic          rise_sda_reg;
    logic          restart_reg;
    logic [7:0]    rx_byte;
    logic          addr_match;

    assign rx_byte    = {rx_shift_reg, sda_i};
    assign addr_match = (rx_byte[7:1] == {SLAVE_ADDR_HI, addr_select_pin_i}); // [R2]

    always_ff @(posedge scl_i or posedge link_idle_reg)
    begin
        if (link_idle_reg)
            rise_sda_reg <= 1'b1;
        else
            rise_sda_reg <= sda_i;
    end

    always_ff @(posedge scl_i or posedge link_idle_reg)
    begin
        if (link_idle_reg)
        begin
            phase_reg      <= PH_ADDR;
            bit_cnt_reg    <= 4'h0;
            rx_shift_reg   <= 7'h00;
            rd_first_reg   <= 1'b0;
            wr_tgl_reg     <= 1'b0;
            rd_tgl_reg     <= 1'b0;
            ev_byte_reg    <= 8'h00;
            ev_is_addr_reg <= 1'b0;
        end
        else if (restart_reg)
        begin
            phase_reg    <= PH_ADDR;                                // [R1]
            bit_cnt_reg  <= 4'h1;
            rx_shift_reg <= {6'h00, sda_i};
            rd_first_reg <= 1'b0;
        end
        else if (bit_cnt_reg == BIT_CNT_ACK)
        begin
            bit_cnt_reg <= 4'h0;
            if (phase_reg == PH_READ)
            begin
                if (rd_first_reg)
                    rd_first_reg <= 1'b0;
                else
                begin
                    rd_tgl_reg <= !rd_tgl_reg;                      // [R8]
                    if (sda_i)
                        phase_reg <= PH_IGNORE;                     // [R11]
                end
            end
        end
        else
        begin
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
            rx_shift_reg <= rx_byte[6:0];                           // [R6]
            if (bit_cnt_reg == 4'(BYTE_LAST_BIT))
            begin
                case (phase_reg)
                    PH_ADDR:
                    begin
                        if (!addr_match)
                            phase_reg <= PH_IGNORE;                 // [R24]
                        else if (rx_byte[0])
                        begin
                            phase_reg    <= PH_READ;                // [R4]
                            rd_first_reg <= 1'b1;
                        end
                        else
                            phase_reg <= PH_REG;                    // [R4]
                    end
                    PH_REG:
                    begin
                        ev_byte_reg    <= rx_byte;                  // [R5]
                        ev_is_addr_reg <= 1'b1;
                        wr_tgl_reg     <= !wr_tgl_reg;
                        phase_reg      <= PH_WDATA;
                    end
                    PH_WDATA:
                    begin
                        ev_byte_reg    <= rx_byte;                  // [R7]
                        ev_is_addr_reg <= 1'b0;
                        wr_tgl_reg     <= !wr_tgl_reg;
                    end
                    default:
                        phase_reg <= phase_reg;
                endcase
            end
        end
    end

    // =====================================================================
    // link domain, bus clock falling edge: data line driver
    // =====================================================================
    logic [7:0] tx_shift_reg;
    logic       drive_low_reg;
    logic [7:0] rd_byte_reg;
    logic       ack_due;

    assign ack_due = (phase_reg == PH_REG) || (phase_reg == PH_WDATA) ||
                     ((phase_reg == PH_READ) && rd_first_reg);

    // sda falling while scl was high marks a repeated start
    always_ff @(negedge scl_i or posedge link_idle_reg)
    begin
        if (link_idle_reg)
            restart_reg <= 1'b0;
        else
            restart_reg <= rise_sda_reg && !sda_i;                  // [R1]
    end

    // rd_byte_reg is quiet here: it settles a few reference clocks after the preceding bus clock rise, well before this edge
    always_ff @(negedge scl_i or posedge link_idle_reg)
    begin
        if (link_idle_reg)
        begin
            tx_shift_reg  <= 8'hFF;
            drive_low_reg <= 1'b0;
        end
        else if (rise_sda_reg && !sda_i)
            drive_low_reg <= 1'b0;
        else if (bit_cnt_reg == BIT_CNT_ACK)
            drive_low_reg <= ack_due;                               // [R3] [R9]
        else if ((bit_cnt_reg == 4'h0) && (phase_reg == PH_READ))
        begin
            tx_shift_reg  <= {rd_byte_reg[6:0], 1'b1};              // [R10] [R11]
            drive_low_reg <= !rd_byte_reg[7];
        end
        else if (phase_reg == PH_READ)
        begin
            tx_shift_reg  <= {tx_shift_reg[6:0], 1'b1};             // [R9]
            drive_low_reg <= !tx_shift_reg[7];
        end
        else
            drive_low_reg <= 1'b0;                                  // [R24]
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = drive_low_reg;

    // =====================================================================
    // event crossing into the reference domain
    // =====================================================================
    logic wr_s1_reg, wr_s2_reg, wr_s3_reg;
    logic rd_s1_reg, rd_s2_reg, rd_s3_reg;
    logic wr_event, rd_event;

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            wr_s1_reg <= 1'b0;
            wr_s2_reg <= 1'b0;
            wr_s3_reg <= 1'b0;
            rd_s1_reg <= 1'b0;
            rd_s2_reg <= 1'b0;
            rd_s3_reg <= 1'b0;
        end
        else
        begin
            wr_s1_reg <= wr_tgl_reg;
            wr_s2_reg <= wr_s1_reg;
            wr_s3_reg <= wr_s2_reg;
            rd_s1_reg <= rd_tgl_reg;
            rd_s2_reg <= rd_s1_reg;
            rd_s3_reg <= rd_s2_reg;
        end
    end

    // toggles fall back to zero in idle; those edges are not events
    assign wr_event = (wr_s2_reg != wr_s3_reg) && !link_idle_reg;
    assign rd_event = (rd_s2_reg != rd_s3_reg) && !link_idle_reg;

    // =====================================================================
    // address counter and register file
    // =====================================================================
    logic [ADDR_W-1:0] addr_cnt_reg;
    logic [7:0]        regs_reg [REG_COUNT];

    always_ff @(posedge ref_clk_i)
    begin
        if (regs_rst)
            addr_cnt_reg <= ADDR_FIRST;
        else if (wr_event && ev_is_addr_reg)
            addr_cnt_reg <= ev_byte_reg[ADDR_W-1:0];                // [R5]
        else if (wr_event || rd_event)
            addr_cnt_reg <= addr_step(addr_cnt_reg);                // [R7] [R8] [R10]
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (regs_rst)
        begin
            for (int i = 0; i < REG_COUNT; i++)
                regs_reg[i] <= REG_RESET_VALUE;                     // [R13] [R15]
        end
        else if (wr_event && !ev_is_addr_reg && in_map(addr_cnt_reg))
            regs_reg[addr_cnt_reg] <= ev_byte_reg;                  // [R7]
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (regs_rst)
            rd_byte_reg <= REG_RESET_VALUE;
        else if (in_map(addr_cnt_reg))
            rd_byte_reg <= regs_reg[addr_cnt_reg];                  // [R8] [R10]
        else
            rd_byte_reg <= 8'h00;
    end

    // =====================================================================
    // power management and control outputs
    // =====================================================================
    logic [7:0] pm_a, pm_b, spk, ser, vol;
    logic       all_down;

    assign pm_a = regs_reg[POWER_MANAGEMENT_A];
    assign pm_b = regs_reg[POWER_MANAGEMENT_B];
    assign spk  = regs_reg[SPEAKER_ROUTE];
    assign ser  = regs_reg[SERIAL_MODE];
    assign vol  = regs_reg[VOLUME_MODE];

    assign all_down = (pm_a == 8'h00) && (pm_b == 8'h00);           // [R18]

    always_ff @(posedge ref_clk_i)
    begin
        if (regs_rst)
        begin
            converter_power_o    <= 1'b0;                           // [R13]
            speaker_amp_power_o  <= 1'b0;
            mono_input_power_o   <= 1'b0;
            reference_power_o    <= 1'b0;
            left_phones_power_o  <= 1'b0;
            right_phones_power_o <= 1'b0;
            loop_power_o         <= 1'b0;
            all_blocks_down_o    <= 1'b1;
        end
        else
        begin
            converter_power_o    <= pm_a[CONVERTER_POWER_BIT] && !all_down;   // [R15]
            speaker_amp_power_o  <= pm_a[SPEAKER_AMP_POWER_BIT] && !all_down;
            mono_input_power_o   <= pm_a[MONO_INPUT_POWER_BIT] && !all_down;
            reference_power_o    <= pm_a[REFERENCE_POWER_BIT] && !all_down;
            left_phones_power_o  <= pm_b[LEFT_PHONES_POWER_BIT] && !all_down;
            right_phones_power_o <= pm_b[RIGHT_PHONES_POWER_BIT] && !all_down;
            loop_power_o         <= pm_b[LOOP_POWER_BIT] && !all_down;
            all_blocks_down_o    <= all_down;                       // [R18]
        end
    end

    // speaker output modes
    always_ff @(posedge ref_clk_i)
    begin
        if (regs_rst)
        begin
            speaker_pos_out_drive_o <= 1'b0;
            speaker_neg_out_mid_o   <= 1'b0;
        end
        else
        begin
            speaker_pos_out_drive_o <= pm_a[SPEAKER_AMP_POWER_BIT] &&
                                       spk[SPEAKER_POWER_SAVE_BIT];          // [R20]
            speaker_neg_out_mid_o   <= pm_a[SPEAKER_AMP_POWER_BIT] &&
                                       !spk[SPEAKER_POWER_SAVE_BIT];         // [R20]
        end
    end

    // serial audio edges and volume ramp
    always_ff @(posedge ref_clk_i)
    begin
        if (regs_rst)
        begin
            serial_audio_out_on_fall_o <= 1'b0;
            serial_audio_in_on_rise_o  <= 1'b0;
            frame_clock_polarity_o     <= 1'b0;
            volume_ramp_frames_o       <= VOLUME_RAMP_SLOW;
        end
        else
        begin
            serial_audio_out_on_fall_o <= ser[BIT_CLOCK_POLARITY];           // [R21]
            serial_audio_in_on_rise_o  <= ser[BIT_CLOCK_POLARITY];           // [R21]
            frame_clock_polarity_o     <= ser[FRAME_CLOCK_POLARITY];
            volume_ramp_frames_o       <= vol[VOLUME_TRANSITION_TIME] ?
                                          VOLUME_RAMP_FAST : VOLUME_RAMP_SLOW; // [R22]
        end
    end

    // =====================================================================
    // master clock output divider
    // =====================================================================
    logic [CLK_DIV_W-1:0] clk_div_reg;
    logic [1:0]           rate_sel;

    assign rate_sel = ser[RATE_SELECT_LSB +: 2];

    always_ff @(posedge ref_clk_i)
    begin
        if (regs_rst)
            clk_div_reg <= '0;
        else
            clk_div_reg <= clk_div_reg + 4'h1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (regs_rst)
            clock_out_o <= 1'b0;
        else if (!pm_b[CLOCK_OUTPUT_ENABLE])
            clock_out_o <= 1'b0;                                    // [R19]
        else
            clock_out_o <= clk_div_reg[rate_sel];                   // [R19]
    end

endmodule

`default_nettype wire

// *** tb/ctrl_port_monitor.sv ***
// assertion checker for the control port pins
`timescale 1ns/100ps
`default_nettype none
module ctrl_port_monitor
(
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic sda_oe_o,
    input  wire logic power_down_pin_n_i,
    input  wire logic speaker_amp_power_o,
    input  wire logic reference_power_o,
    input  wire logic all_blocks_down_o,
    input  wire logic clock_out_o,
    input  wire logic speaker_pos_out_drive_o,
    input  wire logic speaker_neg_out_mid_o,
    input  wire logic bus_busy_o
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);
    // ==========================================
    // bus framing
    sequence s_start; scl_i && $fell(sda_i); endsequence
    sequence s_stop; scl_i && $rose(sda_i); endsequence
    property p_start_busy; s_start |-> ##[1:5] bus_busy_o; endproperty
    a_start_busy: assert property (p_start_busy) else $error("no busy after start");
    property p_stop_idle; s_stop |-> ##[1:5] !bus_busy_o; endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("busy after stop");
    property p_oe_low; $changed(sda_oe_o) |-> !scl_i; endproperty
    a_oe_low: assert property (p_oe_low) else $error("data moved, clock high");
    property p_idle; !bus_busy_o |-> !sda_oe_o; endproperty
    a_idle: assert property (p_idle) else $error("data driven on idle bus");
    // ==========================================
    // power and pins
    property p_pdn;
        !power_down_pin_n_i [*5] |=> all_blocks_down_o && !reference_power_o && !clock_out_o;
    endproperty
    a_pdn: assert property (p_pdn) else $error("power-down pin ignored");
    property p_gate; all_blocks_down_o |-> !reference_power_o && !speaker_amp_power_o; endproperty
    a_gate: assert property (p_gate) else $error("block on while all down");
    property p_clk_off; all_blocks_down_o [*3] |-> !clock_out_o; endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock out runs disabled");
    property p_spk;
        (speaker_pos_out_drive_o || speaker_neg_out_mid_o)
            |-> speaker_amp_power_o && !(speaker_pos_out_drive_o && speaker_neg_out_mid_o);
    endproperty
    a_spk: assert property (p_spk) else $error("speaker outputs wrong");
endmodule
`default_nettype wire

// *** tb/i2c_host_model.sv ***
// two-wire bus master model for the control port
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model
(
    input  wire logic sda_i,
    output var logic  scl_o,
    output var logic  sda_pull_o
);
    logic tick = 1'b0;
    initial
    begin
        scl_o = 1'b1; // clock stands still when idle
        sda_pull_o = 1'b0;
        #7;
        forever #32 tick = ~tick;
    end
    // ==========================================
    // bus phases, quarter bit 640 ns
    task automatic q();
        repeat (10) @(posedge tick);
    endtask
    task automatic bit_io(input logic pull, output logic seen);
        sda_pull_o = pull;
        q();
        scl_o = 1'b1;
        q();
        seen = sda_i;
        q();
        scl_o = 1'b0;
        q();
    endtask
    task automatic start(); // also repeated start
        sda_pull_o = 1'b0;
        q();
        scl_o = 1'b1;
        q();
        sda_pull_o = 1'b1;
        q();
        scl_o = 1'b0;
        q();
    endtask
    task automatic stop(); // after nack ends a read
        sda_pull_o = 1'b1;
        q();
        scl_o = 1'b1;
        q();
        sda_pull_o = 1'b0;
        q();
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ack_pull,
                        output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(~tx[i], s);
            rx[i] = s;
        end
        bit_io(ack_pull, s); // ack slot: ack_pull set pulls the line as master ack, clear releases it for device ack
        ack = ~s;
    endtask
endmodule
`default_nettype wire

// *** tb/test_i2c_control_register_port.sv ***
// self-checking bench for the two-wire control port
`timescale 1ns/100ps
`default_nettype none
module test_i2c_control_register_port;
    import ctrl_port_pkg::*;
    logic ref_clk_i, nrst_i, scl_i, sda_i, sda_o, sda_oe_o, addr_select_pin_i, bus_busy_o;
    logic power_down_pin_n_i, converter_power_o, speaker_amp_power_o, mono_input_power_o;
    logic reference_power_o, left_phones_power_o, right_phones_power_o, loop_power_o;
    logic all_blocks_down_o, clock_out_o, speaker_pos_out_drive_o, speaker_neg_out_mid_o;
    logic serial_audio_out_on_fall_o, serial_audio_in_on_rise_o, frame_clock_polarity_o;
    logic [10:0] volume_ramp_frames_o;
    logic        sda_pull, ack;
    logic [7:0]  rx;
    int          miscompares = 0, cmp_count = 0, k;
    ctrl_port dut_u (.*);
    i2c_host_model host_u (.sda_i(sda_i), .scl_o(scl_i), .sda_pull_o(sda_pull));
    assign sda_i = ~(sda_pull | (sda_oe_o & ~sda_o));
    initial
    begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    // ==========================================
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #2;
    endtask
    task automatic chk(input string n, input logic [10:0] s, input logic [10:0] e);
        cmp_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input int n, input logic [31:0] w, input logic stp);
        host_u.start();
        host_u.xfer({SLAVE_ADDR_HI, addr_select_pin_i, 1'b0}, 1'b0, rx, ack);
        chk("addr ack", ack, 1'b1);
        host_u.xfer({1'b0, a}, 1'b0, rx, ack);
        chk("reg ack", ack, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            host_u.xfer(w[31 - 8 * i -: 8], 1'b0, rx, ack);
            chk("data ack", ack, 1'b1);
        end
        if (stp)
            host_u.stop();
        cyc(4);
    endtask
    task automatic rd(input int n, input logic [31:0] e);
        host_u.start();
        host_u.xfer({SLAVE_ADDR_HI, addr_select_pin_i, 1'b1}, 1'b0, rx, ack);
        chk("read ack", ack, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            host_u.xfer(8'hFF, i < n - 1, rx, ack);
            chk("read data", rx, e[31 - 8 * i -: 8]);
        end
        host_u.stop();
        cyc(4);
    endtask
    // ==========================================
    // scenarios
    task automatic t_addr();
        host_u.start();
        host_u.xfer({SLAVE_ADDR_HI, ~addr_select_pin_i, 1'b0}, 1'b0, rx, ack);
        chk("foreign ack", ack, 1'b0);
        host_u.xfer(8'h05, 1'b0, rx, ack);
        chk("ignored ack", ack, 1'b0);
        host_u.stop();
        rd(1, 32'h0);
    endtask
    task automatic t_power();
        wr(7'h00, 2, 32'h1731_0000, 1'b1);
        chk("powers", {converter_power_o, speaker_amp_power_o, mono_input_power_o,
            reference_power_o, left_phones_power_o, right_phones_power_o, loop_power_o,
            all_blocks_down_o}, 8'hFE);
        wr(7'h4F, 2, 32'hA513_0000, 1'b1);
        rd(1, 32'h3100_0000);
        wr(7'h4F, 0, 32'h0, 1'b0);
        rd(3, 32'hA513_3100);
        wr(7'h00, 2, 32'h0, 1'b1);
        chk("all down", {reference_power_o, loop_power_o, all_blocks_down_o}, 3'h1);
        wr(7'h4F, 0, 32'h0, 1'b0);
        rd(1, 32'hA500_0000);
    endtask
    task automatic t_modes();
        wr(7'h00, 4, 32'h1300_8060, 1'b1);
        chk("spk drive", {speaker_pos_out_drive_o, speaker_neg_out_mid_o}, 2'h2);
        chk("edges", {serial_audio_out_on_fall_o, serial_audio_in_on_rise_o}, 2'h3);
        wr(7'h02, 1, 32'h0, 1'b1);
        chk("spk save", {speaker_pos_out_drive_o, speaker_neg_out_mid_o}, 2'h1);
        wr(7'h09, 1, 32'h8000_0000, 1'b1);
        chk("ramp fast", volume_ramp_frames_o, VOLUME_RAMP_FAST);
        wr(7'h01, 1, 32'h0200_0000, 1'b1);
        k = 0;
        repeat (64)
        begin
            ack = clock_out_o;
            cyc(1);
            k += int'(!ack && clock_out_o);
        end
        chk("clock rises", 11'(k), 11'd16);
        wr(7'h00, 2, 32'h0, 1'b1);
        chk("clock off", clock_out_o, 1'b0);
        chk("spk off", {speaker_pos_out_drive_o, speaker_neg_out_mid_o}, 2'h0);
    endtask
    task automatic t_pdn();
        power_down_pin_n_i = 1'b0;
        cyc(10);
        power_down_pin_n_i = 1'b1;
        cyc(6);
        chk("ramp reset", volume_ramp_frames_o, VOLUME_RAMP_SLOW);
        wr(7'h03, 0, 32'h0, 1'b0);
        rd(2, 32'h0);
    endtask
    initial
    begin
        nrst_i = 1'b0;
        power_down_pin_n_i = 1'b1;
        addr_select_pin_i = 1'b1;
        cyc(20);
        nrst_i = 1'b1;
        cyc(6);
        chk("reset down", {all_blocks_down_o, reference_power_o, clock_out_o}, 3'h4);
        chk("ramp", volume_ramp_frames_o, VOLUME_RAMP_SLOW);
        t_addr();
        t_power();
        t_modes();
        t_pdn();
        summarize();
    end
    initial
    begin
        #2000000;
        miscompares++;
        summarize();
    end
endmodule
bind ctrl_port ctrl_port_monitor mon_u (.*);
`default_nettype wire
